// *** rtl/fsf_fifo_status_flags.sv ***
`timescale 1ns/1ns
// Contract
// - Almost-full active when exactly one free word remains.
// - Almost-empty active when exactly one readable word remains.
// - Optional write acknowledge pulse for accepted writes, selectable polarity, default high.
// - Optional overflow pulse for rejected write, selectable polarity, default high.
// - Single-threshold programmable full uses assert value to raise and drop.
// - Dual-threshold programmable full uses separate assert and negate values.
// - Single-threshold programmable empty uses assert value to raise and drop.
// - Dual-threshold programmable empty uses separate assert and negate values.
// - Common-clock occupancy count, selectable width, most significant bits shown.
// - Write-side occupancy count; one clock here, same as common count.
// - Read-side occupancy count; one clock here, same as common count.
// - Fall-through mode counts the word held in the output stage.
module fsf_fifo_status_flags #(
    parameter int COUNT_W = fsf_pkg::CNT_W
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_wr_en,
    input wire logic [fsf_pkg::DATA_W-1:0] i_wr_data,
    input wire logic i_rd_en,
    output logic [fsf_pkg::DATA_W-1:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_full,
    output logic o_empty,
    output logic o_almost_full,
    output logic o_almost_empty,
    output logic o_wr_ack,
    output logic o_overflow,
    output logic o_prog_full,
    output logic o_prog_empty,
    output logic [COUNT_W-1:0] o_data_count,
    output logic [COUNT_W-1:0] o_wr_data_count,
    output logic [COUNT_W-1:0] o_rd_data_count,
    output logic o_irq,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest
);
    localparam int CW = fsf_pkg::CNT_W;
    localparam int AW = fsf_pkg::ADDR_W;

    // ************************************************************
    // Storage and pointers
    // ************************************************************
    logic [fsf_pkg::DATA_W-1:0] mem_q [fsf_pkg::DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [fsf_pkg::DATA_W-1:0] out_q, out_d;
    logic outv_q, outv_d;
    logic ack_q, ack_d, ovf_q, ovf_d;
    logic pf_q, pf_d, pe_q, pe_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic [15:0] pfthr_q, pfthr_d, pethr_q, pethr_d;
    logic [fsf_pkg::EV_W-1:0] ev_q, ev_d;
    logic ack_done_q, ack_done_d;
    logic [31:0] rdata_q, rdata_d;

    logic fwft, mem_empty, mem_full, do_wr, do_rd, load_out, pop;
    logic [CW-1:0] occ, pf_as, pf_ng, pe_as, pe_ng;
    logic [fsf_pkg::EV_W-1:0] ev_set, ev_mask;

    assign fwft = ctrl_q[fsf_pkg::CTRL_FWFT];
    assign mem_empty = (cnt_q == '0);
    // Full counts the output stage too, so occupancy never passes the depth
    assign mem_full = (occ == CW'(fsf_pkg::DEPTH));
    assign do_wr = i_wr_en && !o_full;
    // Standard mode reads straight from memory; fall-through refills output stage
    assign load_out = fwft ? (!mem_empty && (!outv_q || i_rd_en)) : (i_rd_en && !mem_empty);
    assign pop = load_out;
    assign do_rd = pop;
    // Output stage word counted in fall-through
    assign occ = cnt_q + CW'(fwft && outv_q);
    assign pf_as = pfthr_q[CW-1:0];
    assign pf_ng = ctrl_q[fsf_pkg::CTRL_PF_DUAL] ? pfthr_q[fsf_pkg::THR_NEG_LSB +: CW] : pf_as;
    assign pe_as = pethr_q[CW-1:0];
    assign pe_ng = ctrl_q[fsf_pkg::CTRL_PE_DUAL] ? pethr_q[fsf_pkg::THR_NEG_LSB +: CW] : pe_as;
    assign ev_mask = ctrl_q[fsf_pkg::CTRL_MASK_LSB +: fsf_pkg::EV_W];

    // ************************************************************
    // Queue datapath and flags
    // ************************************************************
    always_comb begin
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        out_d = out_q;
        outv_d = fwft ? (outv_q && !i_rd_en) : 1'b0;
        if (do_wr) begin
            wp_d = wp_q + AW'(1);
        end
        if (do_rd) begin
            rp_d = rp_q + AW'(1);
            out_d = mem_q[rp_q];
            outv_d = 1'b1;
        end
        cnt_d = cnt_q + CW'(do_wr) - CW'(do_rd);
        ack_d = do_wr;
        ovf_d = i_wr_en && o_full;
        pf_d = pf_q;
        pe_d = pe_q;
        if (occ >= pf_as) begin
            pf_d = 1'b1;
        end else if (occ < pf_ng) begin
            pf_d = 1'b0;
        end
        if (occ <= pe_as) begin
            pe_d = 1'b1;
        end else if (occ > pe_ng) begin
            pe_d = 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (do_wr) begin
            mem_q[wp_q] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            out_q <= '0;
            outv_q <= 1'b0;
            ack_q <= 1'b0;
            ovf_q <= 1'b0;
            pf_q <= 1'b0;
            pe_q <= 1'b1;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
            outv_q <= outv_d;
            ack_q <= ack_d;
            ovf_q <= ovf_d;
            pf_q <= pf_d;
            pe_q <= pe_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign o_full = mem_full;
    assign o_empty = (occ == '0);
    assign o_rd_data = out_q;
    assign o_rd_valid = outv_q;
    assign o_almost_full = (occ == CW'(fsf_pkg::DEPTH - 1));
    assign o_almost_empty = (occ == CW'(1));
    // Disabled option drives the inactive level
    assign o_wr_ack = (ack_q && ctrl_q[fsf_pkg::CTRL_ACK_EN]) ^ ctrl_q[fsf_pkg::CTRL_ACK_POL];
    assign o_overflow = (ovf_q && ctrl_q[fsf_pkg::CTRL_OVF_EN]) ^ ctrl_q[fsf_pkg::CTRL_OVF_POL];
    assign o_prog_full = pf_q;
    assign o_prog_empty = pe_q;
    // Most significant bits of the count
    assign o_data_count = occ[CW-1 -: COUNT_W];
    assign o_wr_data_count = occ[CW-1 -: COUNT_W];
    assign o_rd_data_count = occ[CW-1 -: COUNT_W];

    // ************************************************************
    // Avalon-MM registers and interrupt
    // ************************************************************
    assign ev_set = {pe_d && !pe_q, pf_d && !pf_q, ovf_d, ack_d};
    assign o_irq = |(ev_q & ev_mask);
    assign o_avs_readdata = rdata_q;
    // One wait cycle: read data registered at the first edge, writes land at the second
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_done_q;

    always_comb begin
        ctrl_d = ctrl_q;
        pfthr_d = pfthr_q;
        pethr_d = pethr_q;
        rdata_d = rdata_q;
        ev_d = ev_q;
        ack_done_d = (i_avs_read || i_avs_write) && !ack_done_q;
        if (i_avs_write && ack_done_q) begin
            case (i_avs_address)
                fsf_pkg::REG_CTRL: ctrl_d = i_avs_writedata;
                fsf_pkg::REG_PFULL: pfthr_d = i_avs_writedata[15:0];
                fsf_pkg::REG_PEMPTY: pethr_d = i_avs_writedata[15:0];
                fsf_pkg::REG_STATUS: ev_d = ev_q & ~i_avs_writedata[fsf_pkg::STATUS_EV_LSB +: fsf_pkg::EV_W];
                default: ev_d = ev_q;
            endcase
        end
        if (i_avs_read && !ack_done_q) begin
            case (i_avs_address)
                fsf_pkg::REG_CTRL: rdata_d = ctrl_q;
                fsf_pkg::REG_PFULL: rdata_d = {16'h0000, pfthr_q};
                fsf_pkg::REG_PEMPTY: rdata_d = {16'h0000, pethr_q};
                fsf_pkg::REG_STATUS: rdata_d = {12'h000, ev_q, 2'h0, pe_q, pf_q, o_almost_empty,
                    o_almost_full, o_empty, o_full, 3'h0, occ};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        // Set wins over a simultaneous clear
        ev_d = ev_d | ev_set;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q <= fsf_pkg::CTRL_RESET;
            pfthr_q <= {3'h0, fsf_pkg::PF_NEGATE_RESET, 3'h0, fsf_pkg::PF_ASSERT_RESET};
            pethr_q <= {3'h0, fsf_pkg::PE_NEGATE_RESET, 3'h0, fsf_pkg::PE_ASSERT_RESET};
            rdata_q <= '0;
            ev_q <= '0;
            ack_done_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            pfthr_q <= pfthr_d;
            pethr_q <= pethr_d;
            rdata_q <= rdata_d;
            ev_q <= ev_d;
            ack_done_q <= ack_done_d;
        end
    end
endmodule

// *** rtl/fsf_pkg.sv ***
package fsf_pkg;
    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam int DEPTH = 16;
    localparam int DATA_W = 8;
    localparam int CNT_W = ADDR_W + 1;

    // ************************************************************
    // Register map (word offsets in bytes)
    // ************************************************************
    localparam int RA_W = 4;
    localparam logic [RA_W-1:0] REG_CTRL = 4'h0;
    localparam logic [RA_W-1:0] REG_PFULL = 4'h4;
    localparam logic [RA_W-1:0] REG_PEMPTY = 4'h8;
    localparam logic [RA_W-1:0] REG_STATUS = 4'hc;
    localparam logic [RA_W-1:0] REG_EVENT = 4'h0 + 4'h0;

    // ************************************************************
    // Control bit positions
    // ************************************************************
    localparam int CTRL_ACK_POL = 0;
    localparam int CTRL_OVF_POL = 1;
    localparam int CTRL_PF_DUAL = 2;
    localparam int CTRL_PE_DUAL = 3;
    localparam int CTRL_ACK_EN = 4;
    localparam int CTRL_OVF_EN = 5;
    localparam int CTRL_FWFT = 6;
    localparam int CTRL_MASK_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0030;

    // Threshold fields: assert bits 4:0, negate bits 12:8
    localparam int THR_NEG_LSB = 8;
    localparam logic [CNT_W-1:0] PF_ASSERT_RESET = 5'h0e;
    localparam logic [CNT_W-1:0] PF_NEGATE_RESET = 5'h0d;
    localparam logic [CNT_W-1:0] PE_ASSERT_RESET = 5'h02;
    localparam logic [CNT_W-1:0] PE_NEGATE_RESET = 5'h03;

    // Event bits
    localparam int EV_W = 4;
    localparam int EV_ACK = 0;
    localparam int EV_OVF = 1;
    localparam int EV_PFULL = 2;
    localparam int EV_PEMPTY = 3;
    localparam int STATUS_EV_LSB = 16;
endpackage

// *** bench/fsf_flags_props.sv ***
`timescale 1ns/1ns
module fsf_flags_props #(parameter int COUNT_W = 5) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic i_avs_write,
    input wire logic o_full,
    input wire logic o_empty,
    input wire logic o_almost_full,
    input wire logic o_almost_empty,
    input wire logic o_wr_ack,
    input wire logic o_overflow,
    input wire logic [COUNT_W-1:0] o_data_count
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // A register write may flip polarity, so it also breaks the quiet spell
    sequence s_ack_quiet; (!i_wr_en && !i_avs_write)[*2]; endsequence
    sequence s_ovf_quiet; (!(i_wr_en && o_full) && !i_avs_write)[*2]; endsequence
    AST_AFULL: assert property (o_almost_full == (o_data_count == 5'h0f)) else $error("afull");
    AST_AEMPTY: assert property (o_almost_empty == (o_data_count == 5'h01)) else $error("aempty");
    AST_ACK: assert property (s_ack_quiet |=> $stable(o_wr_ack)) else $error("ack");
    AST_OVF: assert property (s_ovf_quiet |=> $stable(o_overflow)) else $error("overflow");
    AST_INC: assert property (i_wr_en && !o_full && !i_rd_en |=>
        o_data_count == $past(o_data_count) + 5'h01) else $error("count up");
    AST_DEC: assert property (i_rd_en && !o_empty && !i_wr_en |=>
        o_data_count == $past(o_data_count) - 5'h01) else $error("count down");
    AST_FULL: assert property (o_full == (o_data_count == 5'h10)) else $error("full");
    AST_EMPTY: assert property (o_empty == (o_data_count == 5'h00)) else $error("empty");
endmodule
bind fsf_fifo_status_flags fsf_flags_props #(.COUNT_W(COUNT_W)) i_fsf_flags_props (.i_clock(i_clock),
    .i_rst(i_rst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_avs_write(i_avs_write), .o_full(o_full),
    .o_empty(o_empty), .o_almost_full(o_almost_full), .o_almost_empty(o_almost_empty), .o_wr_ack(o_wr_ack),
    .o_overflow(o_overflow), .o_data_count(o_data_count));

// *** bench/fsf_user_model.sv ***
`timescale 1ns/1ns
module fsf_user_model (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_push,
    input wire logic i_pop,
    output logic o_wr_en,
    output logic [fsf_pkg::DATA_W-1:0] o_wr_data,
    output logic o_rd_en
);
    // Writer ignores full on purpose so that overflow can be provoked
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_wr_data <= 8'h00;
            {o_wr_en, o_rd_en} <= 2'h0;
        end else begin
            o_wr_data <= o_wr_data + 8'h01;
            {o_wr_en, o_rd_en} <= {i_push, i_pop};
        end
    end
endmodule

// *** bench/test_fifo_status_flags.sv ***
`timescale 1ns/1ns
module test_fifo_status_flags;
    logic i_clock = 1'h0, i_rst = 1'h1, push = 1'h0, pop = 1'h0, av_r = 1'h0, av_w = 1'h0;
    logic wr_en, rd_en, full, empty, afull, aempty, ack, ovf, pf, pe, irq, wreq;
    logic [7:0] wr_data;
    logic [4:0] cnt, wcnt, rcnt;
    logic [3:0] av_a = 4'h0;
    logic [31:0] av_d = 32'h0, rdat, q;
    int n_fail = 0, comparisons = 0, n_ack = 0, n_ovf = 0, occ = 0;
    // Step: write, read, cycles, then expected almost full, almost empty, prog full, prog empty, irq
    localparam logic [14:0] STEPS [10] = '{15'h41f5, 15'h4065, 15'h21a0, 15'h2023, 15'h202b,
        15'h4042, 15'h4020, 15'h4144, 15'h2024, 15'h2020};
    fsf_user_model i_fsf_user_model (.i_clock(i_clock), .i_rst(i_rst), .i_push(push), .i_pop(pop),
        .o_wr_en(wr_en), .o_wr_data(wr_data), .o_rd_en(rd_en));
    fsf_fifo_status_flags i_fsf_fifo_status_flags (.i_clock(i_clock), .i_rst(i_rst), .i_wr_en(wr_en),
        .i_wr_data(wr_data), .i_rd_en(rd_en), .o_rd_data(), .o_rd_valid(), .o_full(full), .o_empty(empty),
        .o_almost_full(afull), .o_almost_empty(aempty), .o_wr_ack(ack), .o_overflow(ovf), .o_prog_full(pf),
        .o_prog_empty(pe), .o_data_count(cnt), .o_wr_data_count(wcnt), .o_rd_data_count(rcnt), .o_irq(irq),
        .i_avs_address(av_a), .i_avs_read(av_r), .i_avs_write(av_w), .i_avs_writedata(av_d),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        n_fail += int'(seen !== exp);
    endtask
    // Request held until the edge that sees waitrequest low; read data taken there
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clock);
        {av_w, av_r, av_a, av_d} <= {w, !w, a, d};
        do @(posedge i_clock); while (wreq !== 1'h0);
        q = rdat;
        {av_w, av_r} <= 2'h0;
    endtask
    task automatic op(input logic w, input logic r, input int n);
        @(posedge i_clock);
        {push, pop} <= {w, r};
        repeat (n) @(posedge i_clock);
        {push, pop} <= 2'h0;
        repeat (3) @(negedge i_clock);
    endtask
    task automatic test_done;
        if (n_fail == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge i_clock) {n_ack, n_ovf} <= {n_ack + int'(ack === 1'h1), n_ovf + int'(ovf === 1'h1)};
    initial forever #10 i_clock = ~i_clock;
    initial begin
        repeat (3000) @(posedge i_clock);
        n_fail++;
        test_done;
    end
    initial begin
        repeat (16) @(posedge i_clock);
        i_rst <= 1'h0;
        av(1'h0, fsf_pkg::REG_CTRL, 32'h0);
        chk(q, fsf_pkg::CTRL_RESET);
        av(1'h0, fsf_pkg::REG_STATUS, 32'h0);
        chk(q, 32'h0000_2200);
        av(1'h0, 4'h2, 32'h0);
        chk(q, 32'h0);
        av(1'h1, fsf_pkg::REG_CTRL, 32'h0000_0f30);
        for (int i = 0; i < 10; i++) begin
            if (i == 2) begin
                chk({n_ack, n_ovf}, {32'h10, 32'h2});
                av(1'h0, fsf_pkg::REG_STATUS, 32'h0);
                chk(q, 32'h0007_1110);
                av(1'h1, fsf_pkg::REG_STATUS, 32'h000f_0000);
            end
            if (i == 5) av(1'h1, fsf_pkg::REG_CTRL, 32'h0000_003c);
            op(STEPS[i][14], STEPS[i][13], int'(STEPS[i][12:5]));
            occ = STEPS[i][14] ? ((occ + STEPS[i][12:5] > 16) ? 16 : occ + STEPS[i][12:5]) : occ - STEPS[i][12:5];
            chk({afull, aempty, pf, pe, irq}, STEPS[i][4:0]);
            chk({wcnt, rcnt, cnt}, {3{occ[4:0]}});
        end
        av(1'h1, fsf_pkg::REG_CTRL, 32'h0000_0431);
        repeat (2) @(negedge i_clock);
        chk({ack, irq}, 2'h3);
        test_done;
    end
endmodule
